// ==== src/zric_top.sv ====
/*
 zone release / induct control register bank and zone command logic.
 assumes the host writes one 16-bit word per strobe, synchronous to mclk,
 addressed by word index; zone sensors are synchronous inputs.
*/
`timescale 1ns/1ps
module zric_top
   import zric_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // host word write/read port
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic [11:0] addr,
   input  wire logic [15:0] wdata,
   output logic [15:0]      rdata,
   output logic             rd_valid,
   // accumulation control words (bit zero used here)
   input  wire logic [15:0] up_acc_ctrl,
   input  wire logic [15:0] dn_acc_ctrl,
   // zone configuration and conditions
   input  wire logic        up_external_feed,
   input  wire logic        dn_external_discharge,
   input  wire logic        flow_reverse,
   input  wire logic        up_carton_arrived,
   input  wire logic        dn_carton_arrived,
   // zone commands
   output logic             up_release,
   output logic             dn_release,
   output logic             up_armed,
   output logic             dn_armed,
   output logic             up_run_accept,
   output logic             up_track_load,
   output logic [15:0]      up_track_w1,
   output logic [15:0]      up_track_w2,
   output logic             dn_hold,
   output logic             dn_release_permit
);
   // register storage, one word each
   logic [15:0] up_rel_q;
   logic [15:0] dn_rel_q;
   logic [15:0] up_ind_q;
   logic [15:0] dn_dis_q;
   logic [15:0] fwd_w1_q;
   logic [15:0] fwd_w2_q;
   logic [15:0] rev_w1_q;
   logic [15:0] rev_w2_q;

   // write decode
   wire wr_up_rel = wr_en && (addr == ZRIC_UP_REL_IDX);
   wire wr_dn_rel = wr_en && (addr == ZRIC_DN_REL_IDX);
   wire wr_up_ind = wr_en && (addr == ZRIC_UP_IND_IDX);
   wire wr_dn_dis = wr_en && (addr == ZRIC_DN_DIS_IDX);
   wire wr_fwd_w1 = wr_en && (addr == ZRIC_FWD_W1_IDX);
   wire wr_fwd_w2 = wr_en && (addr == ZRIC_FWD_W2_IDX);
   wire wr_rev_w1 = wr_en && (addr == ZRIC_REV_W1_IDX);
   wire wr_rev_w2 = wr_en && (addr == ZRIC_REV_W2_IDX);

   // read mux; unmapped index reads zero
   logic [15:0] rd_mux;
   always_comb begin
      rd_mux = ZRIC_WORD_RST;
      unique case (addr)
         ZRIC_UP_REL_IDX: rd_mux = up_rel_q;
         ZRIC_DN_REL_IDX: rd_mux = dn_rel_q;
         ZRIC_UP_IND_IDX: rd_mux = up_ind_q;
         ZRIC_DN_DIS_IDX: rd_mux = dn_dis_q;
         ZRIC_FWD_W1_IDX: rd_mux = fwd_w1_q;
         ZRIC_FWD_W2_IDX: rd_mux = fwd_w2_q;
         ZRIC_REV_W1_IDX: rd_mux = rev_w1_q;
         ZRIC_REV_W2_IDX: rd_mux = rev_w2_q;
         default:         rd_mux = ZRIC_WORD_RST;
      endcase
   end

   // mode bits and status decodes
   wire up_mode     = up_acc_ctrl[ZRIC_ACC_MODE_BIT];
   wire dn_mode     = dn_acc_ctrl[ZRIC_ACC_MODE_BIT];
   wire ind_run     = up_external_feed && (up_ind_q == ZRIC_IND_RUN);
   wire ind_track   = up_external_feed && (up_ind_q == ZRIC_IND_TRACK);
   wire dis_hold    = dn_external_discharge && (dn_dis_q == ZRIC_DIS_HOLD);
   wire dis_permit  = dn_external_discharge && (dn_dis_q == ZRIC_DIS_RELEASE);
   // direction picks which induct word pair applies
   wire [15:0] sel_w1 = flow_reverse ? rev_w1_q : fwd_w1_q;
   wire [15:0] sel_w2 = flow_reverse ? rev_w2_q : fwd_w2_q;

   // register writes; the host keeps each release value distinct per release
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         up_rel_q <= ZRIC_WORD_RST;
         dn_rel_q <= ZRIC_WORD_RST;
         up_ind_q <= ZRIC_WORD_RST;
         dn_dis_q <= ZRIC_WORD_RST;
         fwd_w1_q <= ZRIC_WORD_RST;
         fwd_w2_q <= ZRIC_WORD_RST;
         rev_w1_q <= ZRIC_WORD_RST;
         rev_w2_q <= ZRIC_WORD_RST;
      end else begin
         if (wr_up_rel) up_rel_q <= wdata;
         if (wr_dn_rel) dn_rel_q <= wdata;
         if (wr_up_ind) up_ind_q <= wdata;
         if (wr_dn_dis) dn_dis_q <= wdata;
         if (wr_fwd_w1) fwd_w1_q <= wdata;
         if (wr_fwd_w2) fwd_w2_q <= wdata;
         if (wr_rev_w1) rev_w1_q <= wdata;
         if (wr_rev_w2) rev_w2_q <= wdata;
      end
   end

   // read answer one cycle after rd_en
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rdata    <= ZRIC_WORD_RST;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_en;
         if (rd_en) rdata <= rd_mux;
      end
   end

   // induct and discharge commands, registered
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         up_run_accept     <= 1'b0;
         up_track_load     <= 1'b0;
         up_track_w1       <= ZRIC_WORD_RST;
         up_track_w2       <= ZRIC_WORD_RST;
         dn_hold           <= 1'b0;
         dn_release_permit <= 1'b0;
      end else begin
         up_run_accept     <= ind_run;
         up_track_load     <= ind_track;
         up_track_w1       <= sel_w1;
         up_track_w2       <= sel_w2;
         dn_hold           <= dis_hold;
         dn_release_permit <= dis_permit;
      end
   end

   // upstream zone release/arm
   zric_zone_release u_up (
      .mclk           (mclk),
      .reset_n        (reset_n),
      .acc_mode       (up_mode),
      .rel_word       (up_rel_q),
      .carton_arrived (up_carton_arrived),
      .release_pulse  (up_release),
      .armed          (up_armed)
   );

   // downstream zone release/arm
   zric_zone_release u_dn (
      .mclk           (mclk),
      .reset_n        (reset_n),
      .acc_mode       (dn_mode),
      .rel_word       (dn_rel_q),
      .carton_arrived (dn_carton_arrived),
      .release_pulse  (dn_release),
      .armed          (dn_armed)
   );

   // status 4 with external feed runs the zone next cycle
   property p_ind_run;
      @(posedge mclk) disable iff (!reset_n)
         up_external_feed && (up_ind_q == ZRIC_IND_RUN) |=> up_run_accept;
   endproperty
   a_ind_run: assert property (p_ind_run) else $error("induct run missing");

   // induct word ignored without external feed
   property p_ind_gate;
      @(posedge mclk) disable iff (!reset_n)
         !up_external_feed |=> !up_run_accept && !up_track_load;
   endproperty
   a_ind_gate: assert property (p_ind_gate) else $error("induct acted without feed");

   // status 1 loads tracking
   property p_ind_track;
      @(posedge mclk) disable iff (!reset_n)
         up_external_feed && (up_ind_q == ZRIC_IND_TRACK) |=> up_track_load;
   endproperty
   a_ind_track: assert property (p_ind_track) else $error("track load missing");

   // discharge gate
   property p_dis_gate;
      @(posedge mclk) disable iff (!reset_n)
         !dn_external_discharge |=> !dn_hold && !dn_release_permit;
   endproperty
   a_dis_gate: assert property (p_dis_gate) else $error("discharge acted without external");

   // status 5 holds
   property p_dis_hold;
      @(posedge mclk) disable iff (!reset_n)
         dn_external_discharge && (dn_dis_q == ZRIC_DIS_HOLD) |=> dn_hold && !dn_release_permit;
   endproperty
   a_dis_hold: assert property (p_dis_hold) else $error("hold missing");

   // status 1 permits release
   property p_dis_permit;
      @(posedge mclk) disable iff (!reset_n)
         dn_external_discharge && (dn_dis_q == ZRIC_DIS_RELEASE) |=> dn_release_permit;
   endproperty
   a_dis_permit: assert property (p_dis_permit) else $error("permit missing");

   // forward words in forward flow
   property p_fwd;
      @(posedge mclk) disable iff (!reset_n)
         !flow_reverse |=> up_track_w1 == $past(fwd_w1_q) && up_track_w2 == $past(fwd_w2_q);
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward tracking wrong");

   // reverse words in reverse flow
   property p_rev;
      @(posedge mclk) disable iff (!reset_n)
         flow_reverse |=> up_track_w1 == $past(rev_w1_q) && up_track_w2 == $past(rev_w2_q);
   endproperty
   a_rev: assert property (p_rev) else $error("reverse tracking wrong");

   // downstream write of a new value releases within two cycles in mode
   property p_dn_rel;
      @(posedge mclk) disable iff (!reset_n)
         wr_dn_rel && (wdata != dn_rel_q) && dn_mode ##1 dn_mode |=> dn_release;
   endproperty
   a_dn_rel: assert property (p_dn_rel) else $error("downstream release missed");
endmodule

// ==== src/zric_pkg.sv ====
/*
 zone release / induct control constants: register indices, status codes,
 field positions and reset values.
 assumes a host writes 16-bit words by index over the cyclic output image.
*/
package zric_pkg;
   // register word indices on the host port
   localparam logic [11:0] ZRIC_UP_REL_IDX     = 12'h648;
   localparam logic [11:0] ZRIC_DN_REL_IDX     = 12'h649;
   localparam logic [11:0] ZRIC_UP_IND_IDX     = 12'h64A;
   localparam logic [11:0] ZRIC_DN_DIS_IDX     = 12'h64B;
   localparam logic [11:0] ZRIC_FWD_W1_IDX     = 12'h64C;
   localparam logic [11:0] ZRIC_FWD_W2_IDX     = 12'h64D;
   localparam logic [11:0] ZRIC_REV_W1_IDX     = 12'h64E;
   localparam logic [11:0] ZRIC_REV_W2_IDX     = 12'h64F;
   // status word codes
   localparam logic [15:0] ZRIC_IND_RUN        = 16'h0004;
   localparam logic [15:0] ZRIC_IND_TRACK      = 16'h0001;
   localparam logic [15:0] ZRIC_DIS_HOLD       = 16'h0005;
   localparam logic [15:0] ZRIC_DIS_RELEASE    = 16'h0001;
   // accumulation control field
   localparam int          ZRIC_ACC_MODE_BIT   = 0;
   // reset values
   localparam logic [15:0] ZRIC_WORD_RST       = 16'h0000;
   // zone arm state codes
   typedef enum logic [1:0] {
      ZRIC_IDLE     = 2'b00,
      ZRIC_RELEASE  = 2'b01,
      ZRIC_ARMED    = 2'b10
   } zric_zone_e;
endpackage

// ==== src/zric_zone_release.sv ====
/*
 per-zone release detector and arm state machine.
 assumes the release word and mode bit are held registers in mclk domain.
*/
`timescale 1ns/1ps
module zric_zone_release
   import zric_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // control from the register bank
   input  wire logic        acc_mode,
   input  wire logic [15:0] rel_word,
   input  wire logic        carton_arrived,
   // to zone logic
   output logic             release_pulse,
   output logic             armed
);
   logic [15:0] prev_q;         // last seen release word
   zric_zone_e  st_q;           // arm state
   zric_zone_e  st_d;
   wire         rel_change = (rel_word != prev_q);
   wire         rel_evt    = rel_change & acc_mode;

   // remember previous word every cycle so a change counts once
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) prev_q <= ZRIC_WORD_RST;
      else          prev_q <= rel_word;
   end

   // next state: release on change, then arm for the next carton
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ZRIC_IDLE:    if (rel_evt) st_d = ZRIC_RELEASE;
         ZRIC_RELEASE: st_d = ZRIC_ARMED;
         ZRIC_ARMED: begin
            if (rel_evt)             st_d = ZRIC_RELEASE;
            else if (carton_arrived) st_d = ZRIC_IDLE;
         end
         default:      st_d = ZRIC_IDLE;
      endcase
   end

   // state and registered outputs
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_q          <= ZRIC_IDLE;
         release_pulse <= 1'b0;
         armed         <= 1'b0;
      end else begin
         st_q          <= st_d;
         release_pulse <= rel_evt;
         armed         <= (st_d == ZRIC_ARMED) | (st_d == ZRIC_RELEASE);
      end
   end

   // a change under accumulation mode gives one release pulse next cycle
   property p_rel_pulse;
      @(posedge mclk) disable iff (!reset_n)
         (rel_word != prev_q) && acc_mode |=> release_pulse;
   endproperty
   a_rel_pulse: assert property (p_rel_pulse) else $error("release missed");

   // no release when mode bit clear
   property p_no_rel_mode_off;
      @(posedge mclk) disable iff (!reset_n)
         !acc_mode |=> !release_pulse;
   endproperty
   a_no_rel_mode_off: assert property (p_no_rel_mode_off) else $error("release without mode");

   // armed stands with every release pulse; a carton can clear it no sooner than one cycle later
   property p_arm_after;
      @(posedge mclk) disable iff (!reset_n)
         release_pulse |-> armed;
   endproperty
   a_arm_after: assert property (p_arm_after) else $error("not armed after release");

   // steady word gives no release
   property p_steady;
      @(posedge mclk) disable iff (!reset_n)
         $stable(rel_word) ##1 $stable(rel_word) |=> !release_pulse;
   endproperty
   a_steady: assert property (p_steady) else $error("release on steady word");
endmodule

// ==== tb/zric_host_model.sv ====
/*
 host controller model: writes and reads 16-bit words by index.
 assumes the device takes a request on a rising mclk edge.
*/
`timescale 1ns/1ps
module zric_host_model (
   // clock
   input  wire logic        mclk,
   // word port toward the device
   output logic             wr_en,
   output logic             rd_en,
   output logic [11:0]      addr,
   output logic [15:0]      wdata,
   input  wire logic [15:0] rdata,
   input  wire logic        rd_valid
);
   logic [15:0] rel_cnt = 16'h0100; // last release value sent
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr  = 12'h000;
      wdata = 16'h0000;
   end
   // one word; gap idle cycles first, released lines show inverse
   task automatic write_word(input logic [11:0] a, input logic [15:0] d, input int gap);
      repeat (gap) @(negedge mclk);
      @(negedge mclk);
      addr  = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge mclk);
      wr_en = 1'b0;
      addr  = ~a;
      wdata = ~d;
   endtask
   // fresh value each time, an unchanged word releases nothing
   task automatic release_cmd(input logic [11:0] a, input int gap);
      rel_cnt = rel_cnt + 16'h0001;
      write_word(a, rel_cnt, gap);
   endtask
   // read; answer awaited a bounded number of cycles
   task automatic read_word(input logic [11:0] a, output logic [15:0] d);
      @(negedge mclk);
      addr  = a;
      rd_en = 1'b1;
      @(negedge mclk);
      rd_en = 1'b0;
      addr  = ~a;
      for (int i = 0; i < 3 && rd_valid !== 1'b1; i++) @(negedge mclk);
      d = (rd_valid === 1'b1) ? rdata : 16'hXXXX;
   endtask
endmodule

// ==== tb/zric_top_tb.sv ====
/*
 self-checking bench for the zone release / induct control bank.
 assumes the host model drives the word port; levels driven here.
*/
`timescale 1ns/1ps
module zric_top_tb
   import zric_pkg::*;
;
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic        wr_en, rd_en, rd_valid;
   logic [11:0] addr;
   logic [15:0] wdata, rdata, up_track_w1, up_track_w2, rd;
   logic [15:0] up_acc_ctrl = 16'h0000;
   logic [15:0] dn_acc_ctrl = 16'h0000;
   logic [1:0]  arrive = 2'b00; // carton sensors, bit1 downstream
   logic        ext_feed = 1'b0;
   logic        ext_dis = 1'b0;
   logic        flow_reverse = 1'b0;
   logic        up_release, dn_release, up_armed, dn_armed;
   logic        up_run_accept, up_track_load, dn_hold, dn_release_permit;
   int          err_total = 0;
   int          n_tests = 0;
   int          cyc = 0;
   wire  [1:0]  rel = {dn_release, up_release};
   wire  [1:0]  arm = {dn_armed, up_armed};
   initial begin
      forever #25 mclk = ~mclk;
   end
   zric_host_model host (.mclk(mclk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
      .rdata(rdata), .rd_valid(rd_valid));
   zric_top dut (.mclk(mclk), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid), .up_acc_ctrl(up_acc_ctrl),
      .dn_acc_ctrl(dn_acc_ctrl), .up_external_feed(ext_feed), .dn_external_discharge(ext_dis),
      .flow_reverse(flow_reverse), .up_carton_arrived(arrive[0]), .dn_carton_arrived(arrive[1]),
      .up_release(up_release), .dn_release(dn_release), .up_armed(up_armed), .dn_armed(dn_armed),
      .up_run_accept(up_run_accept), .up_track_load(up_track_load), .up_track_w1(up_track_w1),
      .up_track_w2(up_track_w2), .dn_hold(dn_hold), .dn_release_permit(dn_release_permit));
   // hang guard, well above the fewer than two hundred cycles needed
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 4000) begin
         err_total++;
         results();
      end
   end
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({15'h0000, got}, {15'h0000, exp});
   endtask
   // watch a zone's release pulse for a few cycles
   task automatic wait_rel(input int z, input logic exp);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 4 && !seen; i++) begin
         @(negedge mclk);
         seen = (rel[z] === 1'b1);
      end
      chk_bit(seen, exp);
   endtask
   task automatic settle();
      repeat (2) @(negedge mclk);
   endtask
   // reset values, read back of every word, unmapped index
   task automatic sc_regs();
      chk_bit(|{rel, arm, up_run_accept, up_track_load, dn_hold, dn_release_permit}, 1'b0);
      for (int i = 0; i < 8; i++) begin
         host.read_word(ZRIC_UP_REL_IDX + 12'(i), rd);
         chk_word(rd, ZRIC_WORD_RST);
         host.write_word(ZRIC_UP_REL_IDX + 12'(i), 16'hA5A0 + 16'(i), i % 2);
         host.read_word(ZRIC_UP_REL_IDX + 12'(i), rd);
         chk_word(rd, 16'hA5A0 + 16'(i));
      end
      host.write_word(12'h650, 16'hFFFF, 0);
      host.read_word(12'h650, rd);
      chk_word(rd, 16'h0000);
   endtask
   // release and arm, unchanged word, arrival, mode bit cleared
   task automatic sc_release(input int z);
      logic [11:0] a;
      a = z ? ZRIC_DN_REL_IDX : ZRIC_UP_REL_IDX;
      if (z) dn_acc_ctrl = 16'h0001;
      else up_acc_ctrl = 16'h0001;
      host.release_cmd(a, z);
      wait_rel(z, 1'b1);
      chk_bit(arm[z], 1'b1);
      @(negedge mclk);
      chk_bit(rel[z], 1'b0);
      host.write_word(a, host.rel_cnt, 0);
      wait_rel(z, 1'b0);
      chk_bit(arm[z], 1'b1);
      arrive[z] = 1'b1;
      @(negedge mclk);
      arrive[z] = 1'b0;
      settle();
      chk_bit(arm[z], 1'b0);
      if (z) dn_acc_ctrl = 16'hFFFE;
      else up_acc_ctrl = 16'hFFFE;
      host.release_cmd(a, 0);
      wait_rel(z, 1'b0);
      if (z) dn_acc_ctrl = 16'h0001;
      else up_acc_ctrl = 16'h0001;
      wait_rel(z, 1'b0);
   endtask
   // induct and discharge status codes, gated by external conveyor
   task automatic sc_status();
      @(negedge mclk);
      ext_feed = 1'b1;
      ext_dis = 1'b1;
      host.write_word(ZRIC_UP_IND_IDX, ZRIC_IND_RUN, 0);
      host.write_word(ZRIC_DN_DIS_IDX, ZRIC_DIS_HOLD, 0);
      settle();
      chk_bit(up_run_accept, 1'b1);
      chk_bit(up_track_load, 1'b0);
      chk_bit(dn_hold, 1'b1);
      chk_bit(dn_release_permit, 1'b0);
      host.write_word(ZRIC_UP_IND_IDX, ZRIC_IND_TRACK, 0);
      host.write_word(ZRIC_DN_DIS_IDX, ZRIC_DIS_RELEASE, 0);
      settle();
      chk_bit(up_run_accept, 1'b0);
      chk_bit(up_track_load, 1'b1);
      chk_bit(dn_hold, 1'b0);
      chk_bit(dn_release_permit, 1'b1);
      ext_feed = 1'b0;
      ext_dis = 1'b0;
      settle();
      chk_bit(up_track_load, 1'b0);
      chk_bit(dn_release_permit, 1'b0);
   endtask
   // tracking pair follows flow direction
   task automatic sc_track();
      host.write_word(ZRIC_FWD_W1_IDX, 16'h1234, 0);
      host.write_word(ZRIC_FWD_W2_IDX, 16'h5678, 0);
      host.write_word(ZRIC_REV_W1_IDX, 16'h9ABC, 0);
      host.write_word(ZRIC_REV_W2_IDX, 16'hDEF0, 0);
      settle();
      chk_word(up_track_w1, 16'h1234);
      chk_word(up_track_w2, 16'h5678);
      flow_reverse = 1'b1;
      settle();
      chk_word(up_track_w1, 16'h9ABC);
      chk_word(up_track_w2, 16'hDEF0);
   endtask
   // mid-run reset clears words and outputs, checked on a sample of each
   task automatic sc_reset();
      reset_n = 1'b0;
      repeat (2) @(negedge mclk);
      reset_n = 1'b1;
      @(negedge mclk);
      chk_bit(|{rel, arm, up_run_accept, up_track_load, dn_hold, dn_release_permit}, 1'b0);
      chk_word(up_track_w1, ZRIC_WORD_RST);
      host.read_word(ZRIC_REV_W1_IDX, rd);
      chk_word(rd, ZRIC_WORD_RST);
   endtask
   initial begin
      repeat (5) @(negedge mclk);
      reset_n = 1'b1;
      @(negedge mclk);
      sc_regs();
      sc_release(0);
      sc_release(1);
      sc_status();
      sc_track();
      sc_reset();
      results();
   end
endmodule
